// File: tmr_timer.sv
// How it works
// - Count advances each enabled clock; read-only pair
// - Count zeroed by shared clear bit and, in PWM mode, at cycle end
// - Count low read latches upper byte
// - Capture input one stores current count
// - Capture one low read latches upper byte
// - Compare mode toggles output at compare match
// - Compare mode commits compare value immediately
// - Compare low stored; high write commits word
// - PWM compare commit waits for cycle end or shared clear
// - Compare bytes read back as last written
// - PWM period register, applied at cycle end or shared clear
// - Period low stored; high write commits word
// - PWM period bytes read back as written
// - Compare mode: second register captures count
// - Second capture low read latches upper byte
// - Shared clear zeroes count and prescaler
// - Shared register holds per-timer interrupt enables
// - Sixteen-bit counter behind fifteen-bit prescaler
// - PWM output low after compare, high after period
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module tmr_timer #(
   parameter int unsigned CNT_W = tmr_pkg::CNT_W,
   parameter int unsigned PSC_W = tmr_pkg::PSC_W
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // APB slave
   input  wire tmr_pkg::tmr_apb_req_t  apbReq,
   output tmr_pkg::tmr_apb_rsp_t       apbRsp,
   // Capture and external clock pins
   input  wire logic                   captureInputOne,
   input  wire logic                   captureInputTwo,
   input  wire logic                   extClkIn,
   // Timer output pin and interrupt enables
   output logic                        timerOutputPin,
   output logic [tmr_pkg::NUM_TIMERS-1:0] timerIrqEn
);

   tmr_pkg::tmr_state_t st_r;
   tmr_pkg::tmr_state_t n;

   logic [2:0] pinSync;
   logic       pscTick;
   logic       srcPulse;
   logic       setup;
   logic       setupRd;
   logic       wrDone;
   logic       capOneEv;
   logic       capTwoEv;
   logic       cycEnd;
   logic [CNT_W-1:0] cmpNext;

   // ----------------------------------------------------------------
   // Pin synchronisers and prescaler
   // ----------------------------------------------------------------
   tmr_sync #(
      .W (3)
   ) u_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .async  ({extClkIn, captureInputTwo, captureInputOne}),
      .synced (pinSync)
   );

   // External clock counts rising edges of the synchronised pin
   assign srcPulse = st_r.cfg.extClk ? (pinSync[2] & ~st_r.pinPrev[2])
                                     : 1'b1;

   tmr_prescaler #(
      .W (PSC_W)
   ) u_psc (
      .clk      (clk),
      .rst_n    (rst_n),
      .clear    (st_r.clr),
      .srcPulse (srcPulse),
      .divide   (st_r.cfg.presc),
      .tick     (pscTick)
   );

   // ----------------------------------------------------------------
   // Edge selection
   // ----------------------------------------------------------------
   function automatic logic edgeHit(input logic prev, input logic cur,
                                    input logic [1:0] sel);
      logic r;
      logic f;
      r = cur & ~prev;
      f = prev & ~cur;
      unique case (sel)
         tmr_pkg::EDGE_NONE: edgeHit = 1'b0;
         tmr_pkg::EDGE_RISE: edgeHit = r;
         tmr_pkg::EDGE_FALL: edgeHit = f;
         tmr_pkg::EDGE_BOTH: edgeHit = r | f;
      endcase
   endfunction : edgeHit

   assign capOneEv = st_r.cfg.capOneEn &
      edgeHit(st_r.pinPrev[0], pinSync[0], st_r.cfg.edgeOne);
   assign capTwoEv = st_r.cfg.ccMode & st_r.cfg.capTwoEn &
      edgeHit(st_r.pinPrev[1], pinSync[1], st_r.cfg.edgeTwo);

   // ----------------------------------------------------------------
   // Bus phases
   // ----------------------------------------------------------------
   // Answer is prepared in the setup cycle so pready comes from a flop
   assign setup   = apbReq.psel & ~apbReq.penable;
   assign setupRd = setup & ~apbReq.pwrite;
   assign wrDone  = apbReq.psel & apbReq.penable & st_r.rsp.pready &
                    apbReq.pwrite;
   assign cycEnd  = ~st_r.cfg.ccMode & pscTick & ~st_r.clr &
                    (st_r.cnt == st_r.perAct - 16'h0001);
   assign cmpNext = st_r.cmpOnePend ? st_r.cmpOnePendV : st_r.cmpOneAct;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n             = st_r;
      n.clr         = 1'b0;
      n.pinPrev     = pinSync;
      n.rsp.pready  = 1'b0;
      n.rsp.pslverr = 1'b0;

      // Counter and output level
      if (st_r.clr) begin
         n.cnt = '0;
         if (!st_r.cfg.ccMode) begin
            n.cmpOneAct  = cmpNext;
            n.cmpOnePend = 1'b0;
            n.perAct     = st_r.perPend ? st_r.perPendV : st_r.perAct;
            n.perPend    = 1'b0;
            n.outLvl     = (cmpNext != 16'h0000);
         end
      end else if (pscTick) begin
         if (st_r.cfg.ccMode) begin
            n.cnt = st_r.cnt + 16'h0001;
            if (st_r.cnt == st_r.cmpOneAct - 16'h0001) begin
               n.outLvl = ~st_r.outLvl;
            end
         end else if (cycEnd) begin
            n.cnt        = '0;
            n.cmpOneAct  = cmpNext;
            n.cmpOnePend = 1'b0;
            n.perAct     = st_r.perPend ? st_r.perPendV : st_r.perAct;
            n.perPend    = 1'b0;
            // A zero compare keeps the pin low: 0% duty
            n.outLvl     = (cmpNext != 16'h0000);
         end else begin
            n.cnt = st_r.cnt + 16'h0001;
            if (st_r.cnt == st_r.cmpOneAct - 16'h0001) begin
               n.outLvl = 1'b0;
            end
         end
      end

      // Captures take the count seen at the event
      if (capOneEv) begin
         n.capOne = st_r.cnt;
      end
      if (capTwoEv) begin
         n.capTwo = st_r.cnt;
      end

      // Reads: count and capture low byte reads latch the upper byte
      if (setup) begin
         n.rsp.pready = 1'b1;
         n.rsp.prdata = '0;
         case (apbReq.paddr)
            tmr_pkg::OFS_CNT_LO: begin
               n.rsp.prdata[7:0] = st_r.cnt[7:0];
               if (setupRd) n.cntHi = st_r.cnt[15:8];
            end
            tmr_pkg::OFS_CNT_HI: n.rsp.prdata[7:0] = st_r.cntHi;
            tmr_pkg::OFS_CAP1_LO: begin
               n.rsp.prdata[7:0] = st_r.capOne[7:0];
               if (setupRd) n.capOneHi = st_r.capOne[15:8];
            end
            tmr_pkg::OFS_CAP1_HI: n.rsp.prdata[7:0] = st_r.capOneHi;
            tmr_pkg::OFS_CMP1_LO: n.rsp.prdata[7:0] = st_r.cmpOneLo;
            tmr_pkg::OFS_CMP1_HI: n.rsp.prdata[7:0] = st_r.cmpOneHi;
            tmr_pkg::OFS_PER_LO: begin
               if (st_r.cfg.ccMode) begin
                  n.rsp.prdata[7:0] = st_r.capTwo[7:0];
                  if (setupRd) n.capTwoHi = st_r.capTwo[15:8];
               end else begin
                  n.rsp.prdata[7:0] = st_r.perLo;
               end
            end
            tmr_pkg::OFS_PER_HI: begin
               n.rsp.prdata[7:0] = st_r.cfg.ccMode ? st_r.capTwoHi
                                                   : st_r.perHi;
            end
            tmr_pkg::OFS_CFG: n.rsp.prdata[23:0] = st_r.cfg;
            tmr_pkg::OFS_SHARED: begin
               n.rsp.prdata[tmr_pkg::SHR_IE_LSB +: tmr_pkg::NUM_TIMERS] =
                  st_r.ie;
            end
            default: n.rsp.pslverr = 1'b1;
         endcase
      end

      // Writes take effect at the completing access edge
      if (wrDone) begin
         case (apbReq.paddr)
            tmr_pkg::OFS_CMP1_LO: n.cmpOneLo = apbReq.pwdata[7:0];
            tmr_pkg::OFS_CMP1_HI: begin
               n.cmpOneHi = apbReq.pwdata[7:0];
               if (st_r.cfg.ccMode) begin
                  n.cmpOneAct  = {apbReq.pwdata[7:0], st_r.cmpOneLo};
                  n.cmpOnePend = 1'b0;
               end else begin
                  n.cmpOnePendV = {apbReq.pwdata[7:0], st_r.cmpOneLo};
                  n.cmpOnePend  = 1'b1;
               end
            end
            // Period is read-only while capturing
            tmr_pkg::OFS_PER_LO: begin
               if (!st_r.cfg.ccMode) n.perLo = apbReq.pwdata[7:0];
            end
            tmr_pkg::OFS_PER_HI: begin
               if (!st_r.cfg.ccMode) begin
                  n.perHi    = apbReq.pwdata[7:0];
                  n.perPendV = {apbReq.pwdata[7:0], st_r.perLo};
                  n.perPend  = 1'b1;
               end
            end
            tmr_pkg::OFS_CFG: n.cfg = tmr_pkg::tmr_cfg_t'(apbReq.pwdata[23:0]);
            tmr_pkg::OFS_SHARED: begin
               n.clr = apbReq.pwdata[tmr_pkg::SHR_CLR_BIT];
               n.ie  = apbReq.pwdata[tmr_pkg::SHR_IE_LSB +:
                                     tmr_pkg::NUM_TIMERS];
            end
            default: n.clr = 1'b0;
         endcase
      end

      // Pin is low whenever the output is disabled
      n.outPin = n.cfg.output_enable_bit & n.outLvl;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r           <= '0;
         st_r.cfg       <= tmr_pkg::CFG_RST;
         st_r.perAct    <= tmr_pkg::PER_RST;
         st_r.cmpOneAct <= tmr_pkg::CMP_RST;
         // Readback shows the period in force out of reset
         st_r.perLo     <= tmr_pkg::PER_RST[7:0];
         st_r.perHi     <= tmr_pkg::PER_RST[15:8];
      end else begin
         st_r <= n;
      end
   end

   assign apbRsp         = st_r.rsp;
   assign timerOutputPin = st_r.outPin;
   assign timerIrqEn     = st_r.ie;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence rdCntLo_s;
      setupRd && apbReq.paddr == tmr_pkg::OFS_CNT_LO;
   endsequence

   sequence wrCmpHi_s;
      wrDone && apbReq.paddr == tmr_pkg::OFS_CMP1_HI;
   endsequence

   count_step_a: assert property (
      pscTick && !st_r.clr && st_r.cfg.ccMode
      |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
      else $error("count did not advance by one");

   count_idle_a: assert property (
      !pscTick && !st_r.clr |=> $stable(st_r.cnt))
      else $error("count changed without tick or clear");

   cnt_latch_a: assert property (
      rdCntLo_s |=> st_r.cntHi == $past(st_r.cnt[15:8]))
      else $error("count high byte not latched");

   latch_hold_a: assert property (
      !rdCntLo_s |=> $stable(st_r.cntHi))
      else $error("count high latch moved without low read");

   cap_one_a: assert property (
      capOneEv |=> st_r.capOne == $past(st_r.cnt))
      else $error("capture one missed count");

   cap_two_a: assert property (
      capTwoEv |=> st_r.capTwo == $past(st_r.cnt))
      else $error("capture two missed count");

   cc_toggle_a: assert property (
      st_r.cfg.ccMode && pscTick && !st_r.clr &&
      st_r.cnt == st_r.cmpOneAct - 16'h0001
      |=> st_r.outLvl != $past(st_r.outLvl))
      else $error("compare match did not toggle");

   cc_commit_a: assert property (
      wrCmpHi_s and st_r.cfg.ccMode
      |=> st_r.cmpOneAct == {$past(apbReq.pwdata[7:0]), $past(st_r.cmpOneLo)})
      else $error("compare not committed at once");

   pwm_hold_a: assert property (
      wrCmpHi_s and !st_r.cfg.ccMode && !cycEnd && !st_r.clr
      |=> st_r.cmpOnePend && st_r.cmpOneAct == $past(st_r.cmpOneAct))
      else $error("pwm compare applied before cycle end");

   pwm_low_a: assert property (
      !st_r.cfg.ccMode && pscTick && !st_r.clr && !cycEnd &&
      st_r.cnt == st_r.cmpOneAct - 16'h0001 |=> !st_r.outLvl)
      else $error("pwm output not low after compare");

   clear_a: assert property (
      st_r.clr |=> st_r.cnt == 16'h0000)
      else $error("shared clear did not zero count");

endmodule : tmr_timer

// File: tmr_pkg.sv
package tmr_pkg;

   // ----------------------------------------------------------------
   // Bus and counter geometry
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W  = 16;
   localparam int unsigned PSC_W  = 15;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CNT_LO  = 8'h00;
   localparam logic [7:0] OFS_CNT_HI  = 8'h04;
   localparam logic [7:0] OFS_CAP1_LO = 8'h08;
   localparam logic [7:0] OFS_CAP1_HI = 8'h0c;
   localparam logic [7:0] OFS_CMP1_LO = 8'h10;
   localparam logic [7:0] OFS_CMP1_HI = 8'h14;
   localparam logic [7:0] OFS_PER_LO  = 8'h18;
   localparam logic [7:0] OFS_PER_HI  = 8'h1c;
   localparam logic [7:0] OFS_CFG     = 8'h20;
   localparam logic [7:0] OFS_SHARED  = 8'h24;

   // ----------------------------------------------------------------
   // Shared control bit positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned SHR_CLR_BIT = 0;
   localparam int unsigned SHR_IE_LSB  = 1;
   localparam int unsigned NUM_TIMERS  = 2;
   localparam int unsigned CFG_W       = 24;
   localparam logic [23:0] CFG_RST     = 24'h00_0000;
   localparam logic [15:0] PER_RST     = 16'hffff;
   localparam logic [15:0] CMP_RST     = 16'h0000;

   // Capture edge selection
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } tmr_apb_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic              pready;
      logic              pslverr;
   } tmr_apb_rsp_t;

   // Configuration word, bit 0 is ccMode
   typedef struct packed {
      logic [PSC_W-1:0] presc;
      logic             extClk;
      logic [1:0]       edgeTwo;
      logic [1:0]       edgeOne;
      logic             capTwoEn;
      logic             capOneEn;
      logic             output_enable_bit;
      logic             ccMode;
   } tmr_cfg_t;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [7:0]       cntHi;
      logic [CNT_W-1:0] capOne;
      logic [7:0]       capOneHi;
      logic [7:0]       cmpOneLo;
      logic [7:0]       cmpOneHi;
      logic [CNT_W-1:0] cmpOneAct;
      logic [CNT_W-1:0] cmpOnePendV;
      logic             cmpOnePend;
      logic [7:0]       perLo;
      logic [7:0]       perHi;
      logic [CNT_W-1:0] perAct;
      logic [CNT_W-1:0] perPendV;
      logic             perPend;
      logic [CNT_W-1:0] capTwo;
      logic [7:0]       capTwoHi;
      tmr_cfg_t         cfg;
      logic [NUM_TIMERS-1:0] ie;
      logic             clr;
      logic [2:0]       pinPrev;
      logic             outLvl;
      logic             outPin;
      tmr_apb_rsp_t     rsp;
   } tmr_state_t;

   typedef struct packed {
      logic [PSC_W-1:0] cnt;
      logic             tick;
   } tmr_psc_t;

endpackage : tmr_pkg

// File: tmr_sync.sv
`timescale 1ns/1ps
module tmr_sync #(
   parameter int unsigned W = 3
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Asynchronous in, synchronised out
   input  wire logic [W-1:0] async,
   output logic      [W-1:0] synced
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } tmr_sync_t;

   tmr_sync_t st_r;
   tmr_sync_t st_nxt;

   // First stage feeds only the second stage
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = async;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign synced = st_r.s2;

endmodule : tmr_sync

// File: tmr_prescaler.sv
`timescale 1ns/1ps
module tmr_prescaler #(
   parameter int unsigned W = tmr_pkg::PSC_W
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         clear,
   input  wire logic         srcPulse,
   input  wire logic [W-1:0] divide,
   // Count enable for the main counter
   output logic              tick
);

   tmr_pkg::tmr_psc_t st_r;
   tmr_pkg::tmr_psc_t st_nxt;

   // Divide ratio is divide+1 source pulses per tick
   always_comb begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      if (clear) begin
         st_nxt.cnt = '0;
      end else if (srcPulse) begin
         if (st_r.cnt >= divide) begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 15'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;

endmodule : tmr_prescaler

// File: tmr_pins_model.sv
`timescale 1ns/1ps
module tmr_pins_model (
   // Clock
   input  wire logic clk,
   // Pins to and from the timer
   output logic      capOne,
   output logic      capTwo,
   output logic      extClk,
   input  wire logic outPin
);
   int   hiLen;
   int   perLen;
   int   runHi;
   int   runPer;
   logic outPrev;

   initial begin
      capOne  = 1'b0;
      capTwo  = 1'b0;
      extClk  = 1'b0;
      outPrev = 1'b0;
      runHi   = 0;
      runPer  = 0;
      hiLen   = 0;
      perLen  = 0;
   end

   // Held for several clocks so the pin synchroniser cannot miss it
   task automatic pulse(input int which);
      @(posedge clk);
      if (which == 1) capOne <= 1'b1;
      else capTwo <= 1'b1;
      repeat (4) @(posedge clk);
      capOne <= 1'b0;
      capTwo <= 1'b0;
   endtask : pulse

   // Slow edges so the pin synchroniser sees every one; idle low after
   task automatic extPulses(input int k);
      repeat (k) begin
         extClk <= 1'b1;
         repeat (4) @(posedge clk);
         extClk <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : extPulses

   // Length of the last high phase and of the last whole period
   always @(posedge clk) begin
      outPrev <= outPin;
      runHi   <= outPin ? runHi + 1 : 0;
      runPer  <= (outPin && !outPrev) ? 1 : runPer + 1;
      if (outPrev && !outPin) hiLen <= runHi;
      if (outPin && !outPrev) perLen <= runPer;
   end
endmodule : tmr_pins_model

// File: timer_counter_register_access_test.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
   failures++; $display("ERROR %s exp %h got %h", nm, exp, got); end end
module timer_counter_register_access_test;
   logic                  clk;
   logic                  rst_n;
   tmr_pkg::tmr_apb_req_t req;
   tmr_pkg::tmr_apb_rsp_t rsp;
   logic                  capOne;
   logic                  capTwo;
   logic                  extClk;
   logic                  outPin;
   logic [1:0]            irqEn;
   int                    failures;
   int                    cmp_count;
   logic [31:0]           q;
   logic                  e;
   logic                  p0;
   logic [7:0]            hiByte;

   tmr_timer dut (.clk(clk), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp),
      .captureInputOne(capOne), .captureInputTwo(capTwo),
      .extClkIn(extClk), .timerOutputPin(outPin), .timerIrqEn(irqEn));
   tmr_pins_model pins (.clk(clk), .capOne(capOne), .capTwo(capTwo),
      .extClk(extClk), .outPin(outPin));

   always #20 clk = ~clk;

   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= w;
      req.paddr   <= a;
      req.pwdata  <= {16'h0000, hiByte, d};
      @(posedge clk);
      req.penable <= 1'b1;
      // No cycle count assumed; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      // Idle edge so a following call never drives psel twice at once
      @(posedge clk);
   endtask : apb

   task automatic clear();
      apb(1'b1, tmr_pkg::OFS_SHARED, 8'h01);
   endtask : clear

   task final_report;
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_map();
      apb(1'b0, tmr_pkg::OFS_PER_LO, 8'h00);
      `CHK("perLo", 8'hff, q[7:0])
      apb(1'b0, tmr_pkg::OFS_PER_HI, 8'h00);
      `CHK("perHi", 8'hff, q[7:0])
      apb(1'b0, 8'h3c, 8'h00);
      `CHK("unmapped", 1'b1, e)
      apb(1'b1, tmr_pkg::OFS_CMP1_LO, 8'h34);
      apb(1'b0, tmr_pkg::OFS_CMP1_LO, 8'h00);
      `CHK("cmpLo", 8'h34, q[7:0])
      apb(1'b0, tmr_pkg::OFS_CMP1_HI, 8'h00);
      `CHK("cmpHi", 8'h00, q[7:0])
      apb(1'b1, tmr_pkg::OFS_CMP1_HI, 8'h12);
      apb(1'b0, tmr_pkg::OFS_CMP1_HI, 8'h00);
      `CHK("cmpHi2", 8'h12, q[7:0])
      $display("reset and map done");
   endtask : t_reset_map

   task automatic t_count_latch();
      clear();
      apb(1'b0, tmr_pkg::OFS_CNT_LO, 8'h00);
      `CHK("cntLoSmall", 1'b1, q[7:0] < 8'h10)
      repeat (700) @(posedge clk);
      apb(1'b0, tmr_pkg::OFS_CNT_HI, 8'h00);
      `CHK("cntHiHeld", 8'h00, q[7:0])
      apb(1'b0, tmr_pkg::OFS_CNT_LO, 8'h00);
      apb(1'b0, tmr_pkg::OFS_CNT_HI, 8'h00);
      `CHK("cntHiLatch", 8'h02, q[7:0])
      apb(1'b1, tmr_pkg::OFS_CNT_HI, 8'h55);
      apb(1'b0, tmr_pkg::OFS_CNT_HI, 8'h00);
      `CHK("cntNoWrite", 8'h02, q[7:0])
      $display("count latch done");
   endtask : t_count_latch

   task automatic t_shared();
      apb(1'b1, tmr_pkg::OFS_SHARED, 8'h06);
      @(posedge clk);
      `CHK("irqEn", 2'b11, irqEn)
      apb(1'b0, tmr_pkg::OFS_SHARED, 8'h00);
      `CHK("shared", 8'h06, q[7:0])
      $display("shared control done");
   endtask : t_shared

   task automatic t_pwm();
      apb(1'b1, tmr_pkg::OFS_CFG, 8'h02);
      apb(1'b1, tmr_pkg::OFS_PER_LO, 8'h0a);
      apb(1'b1, tmr_pkg::OFS_PER_HI, 8'h00);
      apb(1'b1, tmr_pkg::OFS_CMP1_LO, 8'h04);
      apb(1'b1, tmr_pkg::OFS_CMP1_HI, 8'h00);
      apb(1'b0, tmr_pkg::OFS_PER_LO, 8'h00);
      `CHK("perRd", 8'h0a, q[7:0])
      clear();
      repeat (60) @(posedge clk);
      `CHK("pwmHigh", 4, pins.hiLen)
      `CHK("pwmPeriod", 10, pins.perLen)
      $display("pwm done");
   endtask : t_pwm

   task automatic t_capcmp();
      apb(1'b1, tmr_pkg::OFS_CFG, 8'h5f);
      apb(1'b1, tmr_pkg::OFS_CMP1_LO, 8'h20);
      apb(1'b1, tmr_pkg::OFS_CMP1_HI, 8'h00);
      clear();
      repeat (3) @(posedge clk);
      p0 = outPin;
      repeat (50) @(posedge clk);
      `CHK("toggle", ~p0, outPin)
      clear();
      repeat (100) @(posedge clk);
      pins.pulse(1);
      apb(1'b0, tmr_pkg::OFS_CAP1_LO, 8'h00);
      `CHK("capOneLo", 1'b1, q[7:0] > 8'h5f && q[7:0] < 8'h73)
      apb(1'b0, tmr_pkg::OFS_CAP1_HI, 8'h00);
      `CHK("capOneHi", 8'h00, q[7:0])
      clear();
      repeat (300) @(posedge clk);
      pins.pulse(2);
      apb(1'b0, tmr_pkg::OFS_PER_LO, 8'h00);
      apb(1'b0, tmr_pkg::OFS_PER_HI, 8'h00);
      `CHK("capTwoHi", 8'h01, q[7:0])
      $display("capture compare done");
   endtask : t_capcmp

   // External source, divide by two, falling-edge capture one
   task automatic t_ext();
      hiByte = 8'h03;
      apb(1'b1, tmr_pkg::OFS_CFG, 8'h25);
      hiByte = 8'h00;
      clear();
      pins.extPulses(8);
      apb(1'b0, tmr_pkg::OFS_CNT_LO, 8'h00);
      `CHK("extCount", 8'h04, q[7:0])
      pins.pulse(1);
      repeat (4) @(posedge clk);
      apb(1'b0, tmr_pkg::OFS_CAP1_LO, 8'h00);
      `CHK("capFall", 8'h04, q[7:0])
      $display("external clock done");
   endtask : t_ext

   task automatic t_midreset();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("outRst", 1'b0, outPin)
      `CHK("irqRst", 2'b00, irqEn)
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, tmr_pkg::OFS_PER_HI, 8'h00);
      `CHK("perHiRst", 8'hff, q[7:0])
      apb(1'b0, tmr_pkg::OFS_CMP1_LO, 8'h00);
      `CHK("cmpLoRst", 8'h00, q[7:0])
      $display("mid-run reset done");
   endtask : t_midreset

   initial begin
      clk       = 1'b0;
      rst_n     = 1'b0;
      req       = '0;
      hiByte    = 8'h00;
      failures  = 0;
      cmp_count = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset_map();
      t_count_latch();
      t_shared();
      t_pwm();
      t_capcmp();
      t_ext();
      t_midreset();
      final_report();
   end

   // Run needs under two thousand clocks; far beyond that means a hang
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      final_report();
   end
endmodule : timer_counter_register_access_test
